/* File: swfp_pkg.sv */
// Purpose: shared constants and types for the switch fault protection control
// Assumes: 20 MHz ref_clk, AXI4-Lite register access with 32-bit data
// Notes:   every count of cycles is derived here from a time in its own unit
package swfp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int CLK_MHZ       = 20;
   localparam int DEGLITCH_NS   = 3000;
   localparam int DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // retry interval length is arbitrary, no figure is given for it
   localparam int RETRY_US      = 1000;
   localparam int RETRY_CYC     = RETRY_US * CLK_MHZ;
   localparam int FOLD_COUNT    = 7;

   // ---------------------------------------------------------------
   // current limit derating over temperature (degrees C)
   // ---------------------------------------------------------------
   localparam logic [7:0] KNEE_C       = 8'h3C;
   localparam logic [7:0] UPPER_C      = 8'h96;
   localparam logic [7:0] SCALE_FULL   = 8'hFF;
   localparam int         DERATE_MUL   = 45;
   localparam int         DERATE_SHIFT = 4;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam int         CTRL_STBY   = 0;
   localparam int         CTRL_VAR    = 1;
   localparam int         STAT_FAULT  = 0;
   localparam int         STAT_ABS    = 1;
   localparam int         STAT_REL    = 2;
   localparam int         STAT_OC     = 3;
   localparam int         STAT_RETRY  = 4;
   localparam int         STAT_HALVED = 5;
   localparam int         STAT_SWITCH = 6;
   localparam int         STAT_UVLO   = 7;
   localparam int         STAT_LIMINT = 8;
   localparam int         STAT_RECOV  = 9;
   localparam int         STAT_CNT    = 12;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      VAR_LOWLIM = 2'b00,
      VAR_FOLD   = 2'b01,
      VAR_FIXED  = 2'b10
   } swfp_variant_t;

   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_HOLD    = 2'b01,
      ST_RECOVER = 2'b10
   } swfp_state_t;

   localparam swfp_variant_t VARIANT_RST = VAR_FOLD;

endpackage : swfp_pkg

/* File: swfp_sync.sv */
// Purpose: two flip-flop synchroniser for a vector of independent levels
// Assumes: each bit is a slow level; bits are not related to each other
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module swfp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : swfp_sync

/* File: swfp_ctrl.sv */
// Purpose: fault handling control of a single-channel high-side switch
// Assumes: monitor comparators arrive as asynchronous pins; fet_temp_c is
//          produced by on-chip logic on ref_clk
// Notes:   variant and standby are software controls over AXI4-Lite
`timescale 1ns/1ps
// Function
// - thermal or current fault turns switch off
// - fault state drives sense fault, pin too
// - hold off until hold low, retry, clear
// - thermal fault on absolute or relative excess
// - absolute fault clears after hysteresis cooling
// - relative fault clears when retry expires
// - current limit turns channel off after deglitch
// - overcurrent passes 3 us deglitch first
// - seven consecutive faults halve the limit, except in VAR_LOWLIM
// - standby or clean cycle restores limit
// - bad limit resistor selects internal limit
// - fixed variant always uses internal limit
// - fixed limit flat, then derates linearly
// - undervoltage lockout with fall/rise levels
// - load dump keeps present switch state
// - reverse battery forces switch on
// - sense fault stays until output rises; enable low also clears it
// - only fixed variant drives fault pin
module swfp_ctrl
   import swfp_pkg::*;
#(
   parameter int RETRY_CYCLES = RETRY_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // controller pins
   input  wire logic        en_pin,
   input  wire logic        hold_pin,
   // monitors
   input  wire logic        limit_set_ok_pin,
   input  wire logic        uv_fall_pin,
   input  wire logic        uv_rise_pin,
   input  wire logic        load_dump_pin,
   input  wire logic        rev_batt_pin,
   input  wire logic        vout_high_pin,
   input  wire logic        temp_abs_pin,
   input  wire logic        temp_cool_pin,
   input  wire logic        temp_rel_pin,
   input  wire logic [3:0]  i_over_pin,
   input  wire logic [7:0]  fet_temp_c,
   // switch and indication
   output logic             switch_on,
   output logic             sense_output,
   output logic             fault_open_drain_out,
   output logic             fault_open_drain_oe,
   output logic             limit_internal,
   output logic             limit_halved,
   output logic [7:0]       limit_scale
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [14:0] pin_s;
   logic        en_s, hold_s, res_ok_s, uvf_s, uvr_s, ld_s, rev_s, vout_s;
   logic        abs_temp_threshold_s, tcool_s, relative_temp_threshold_s;
   logic [3:0]  i_over_s;

   swfp_sync #(.W(15)) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       ({i_over_pin, temp_rel_pin, temp_cool_pin, temp_abs_pin, vout_high_pin,
                 rev_batt_pin, load_dump_pin, uv_rise_pin, uv_fall_pin,
                 limit_set_ok_pin, hold_pin, en_pin}),
      .q       (pin_s)
   );

   assign {i_over_s, relative_temp_threshold_s, tcool_s, abs_temp_threshold_s, vout_s, rev_s, ld_s, uvr_s, uvf_s,
           res_ok_s, hold_s, en_s} = pin_s;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   localparam logic [6:0]  DG_MAX    = 7'(DEGLITCH_CYC - 1);
   localparam logic [2:0]  FOLD_MAX  = 3'(FOLD_COUNT);
   localparam logic [23:0] RETRY_MAX = 24'(RETRY_CYCLES - 1);

   swfp_state_t   state_reg, state_next;
   swfp_variant_t variant_reg;
   logic          standby_reg;
   logic          abs_flag_reg, rel_flag_reg, oc_flag_reg;
   logic [6:0]    dg_cnt_reg;
   logic [23:0]   retry_cnt_reg;
   logic          retry_done_reg;
   logic          uvlo_reg;
   logic [2:0]    fold_cnt_reg;
   logic          on_seen_reg;
   logic          sw_next;
   logic          fault_any, trip, oc_raw, fixed_var;

   assign fault_any = abs_flag_reg | rel_flag_reg | oc_flag_reg;
   assign trip      = (state_reg != ST_HOLD) && fault_any;
   assign fixed_var = (variant_reg == VAR_FIXED);
   // comparator index: bit0 internal reference, bit1 halved reference
   assign oc_raw    = i_over_s[{limit_halved, limit_internal}] & switch_on;

   // ---------------------------------------------------------------
   // fault detection
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         abs_flag_reg <= 1'b0;
      end else if (abs_temp_threshold_s) begin
         abs_flag_reg <= 1'b1;
      end else if (tcool_s) begin
         abs_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rel_flag_reg <= 1'b0;
      end else if (relative_temp_threshold_s) begin
         rel_flag_reg <= 1'b1;
      end else if (retry_done_reg && state_reg == ST_HOLD) begin
         rel_flag_reg <= 1'b0;
      end
   end

   // short pulses through the limit are ignored; cost is 3 us of overshoot
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dg_cnt_reg  <= '0;
         oc_flag_reg <= 1'b0;
      end else begin
         if (!oc_raw) begin
            dg_cnt_reg <= '0;
         end else if (dg_cnt_reg != DG_MAX) begin
            dg_cnt_reg <= dg_cnt_reg + 7'h01;
         end
         if (oc_raw && dg_cnt_reg == DG_MAX) begin
            oc_flag_reg <= 1'b1;
         end else if (!oc_raw) begin
            oc_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         uvlo_reg <= 1'b1;
      end else if (uvf_s) begin
         uvlo_reg <= 1'b1;
      end else if (uvr_s) begin
         uvlo_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // retry interval
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         retry_cnt_reg  <= '0;
         retry_done_reg <= 1'b1;
      end else if (trip) begin
         retry_cnt_reg  <= '0;
         retry_done_reg <= 1'b0;
      end else if (!retry_done_reg) begin
         if (retry_cnt_reg == RETRY_MAX) begin
            retry_done_reg <= 1'b1;
         end else begin
            retry_cnt_reg <= retry_cnt_reg + 24'h000001;
         end
      end
   end

   // ---------------------------------------------------------------
   // fault state machine
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (fault_any) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!hold_s && retry_done_reg && !fault_any) begin
               state_next = en_s ? ST_RECOVER : ST_RUN;
            end
         end
         ST_RECOVER: begin
            if (fault_any) begin
               state_next = ST_HOLD;
            end else if (vout_s || !en_s) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // reverse battery outranks the load dump freeze, which outranks faults
   always_comb begin
      if (rev_s) begin
         sw_next = 1'b1;
      end else if (ld_s) begin
         sw_next = switch_on;
      end else begin
         sw_next = en_s && !uvlo_reg && !standby_reg && !fault_any
                   && (state_reg != ST_HOLD);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg            <= ST_RUN;
         switch_on            <= 1'b0;
         sense_output         <= 1'b0;
         fault_open_drain_oe  <= 1'b0;
         fault_open_drain_out <= 1'b0;
      end else begin
         state_reg            <= state_next;
         switch_on            <= sw_next;
         sense_output         <= (state_next != ST_RUN);
         // drive low while healthy; releasing the pin signals the fault
         fault_open_drain_oe  <= fixed_var && (state_next == ST_RUN);
         fault_open_drain_out <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // current limit selection and foldback
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fold_cnt_reg <= '0;
         limit_halved <= 1'b0;
         on_seen_reg  <= 1'b0;
      end else if (trip) begin
         if (fold_cnt_reg != FOLD_MAX) begin
            fold_cnt_reg <= fold_cnt_reg + 3'h1;
         end
         if (fold_cnt_reg == FOLD_MAX - 3'h1 && (variant_reg == VAR_FOLD || fixed_var)) begin
            limit_halved <= 1'b1;
         end
         on_seen_reg <= 1'b0;
      end else if (standby_reg || (on_seen_reg && !switch_on)) begin
         fold_cnt_reg <= '0;
         limit_halved <= 1'b0;
         on_seen_reg  <= 1'b0;
      end else if (switch_on && state_reg == ST_RUN) begin
         on_seen_reg <= 1'b1;
      end
   end

   logic [15:0] derate_prod;

   always_comb begin
      derate_prod = 16'((fet_temp_c - KNEE_C) * DERATE_MUL) >> DERATE_SHIFT;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         limit_internal <= 1'b0;
         limit_scale    <= SCALE_FULL;
      end else begin
         limit_internal <= fixed_var || !res_ok_s;
         if (!fixed_var || fet_temp_c <= KNEE_C) begin
            limit_scale <= SCALE_FULL;
         end else if (fet_temp_c >= UPPER_C || derate_prod > 16'h00FF) begin
            limit_scale <= 8'h00;
         end else begin
            limit_scale <= SCALE_FULL - derate_prod[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------------------------
   function automatic logic [1:0] reg_sel(input logic [7:0] a);
      case (a)
         ADDR_CTRL: reg_sel = 2'h1;
         ADDR_STAT: reg_sel = 2'h2;
         default:   reg_sel = 2'h0;
      endcase
   endfunction : reg_sel

   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;
   logic [31:0] stat_word;

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_comb begin
      stat_word                 = '0;
      stat_word[STAT_FAULT]     = sense_output;
      stat_word[STAT_ABS]       = abs_flag_reg;
      stat_word[STAT_REL]       = rel_flag_reg;
      stat_word[STAT_OC]        = oc_flag_reg;
      stat_word[STAT_RETRY]     = retry_done_reg;
      stat_word[STAT_HALVED]    = limit_halved;
      stat_word[STAT_SWITCH]    = switch_on;
      stat_word[STAT_UVLO]      = uvlo_reg;
      stat_word[STAT_LIMINT]    = limit_internal;
      stat_word[STAT_RECOV]     = (state_reg == ST_RECOVER);
      stat_word[STAT_CNT+:3]    = fold_cnt_reg;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr_reg   <= '0;
         w_data_reg    <= '0;
         w_strb_reg    <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (reg_sel(aw_addr_reg) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         standby_reg <= 1'b0;
         variant_reg <= VARIANT_RST;
      end else if (wr_fire && reg_sel(aw_addr_reg) == 2'h1 && w_strb_reg[0]) begin
         standby_reg <= w_data_reg[CTRL_STBY];
         variant_reg <= swfp_variant_t'(w_data_reg[CTRL_VAR+:2]);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            2'h1:    s_axi_rdata <= {29'h0, variant_reg, standby_reg};
            2'h2:    s_axi_rdata <= stat_word;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   trip_off_a: assert property (state_reg == ST_RUN && fault_any && !rev_s && !ld_s |=> !switch_on)
      else $error("switch stayed on after a fault");
   fault_ind_a: assert property (trip |=> sense_output && state_reg == ST_HOLD)
      else $error("fault not indicated after trip");
   hold_off_a: assert property (state_reg == ST_HOLD && (hold_s || !retry_done_reg) |=> state_reg == ST_HOLD)
      else $error("hold state left too early");
   abs_hys_a: assert property (abs_flag_reg && !tcool_s |=> abs_flag_reg)
      else $error("absolute thermal fault cleared without cooling");
   rel_retry_a: assert property (rel_flag_reg && !retry_done_reg |=> rel_flag_reg)
      else $error("relative thermal fault cleared before retry expiry");
   oc_deglitch_a: assert property ($rose(oc_flag_reg) |-> $past(dg_cnt_reg) == DG_MAX && $past(oc_raw))
      else $error("overcurrent flagged before deglitch time");
   fold_half_a: assert property ($rose(limit_halved) |-> $past(fold_cnt_reg) == 3'h6
      && variant_reg inside {VAR_FOLD, VAR_FIXED})
      else $error("limit halved at wrong fault count");
   uvlo_off_a: assert property (uvlo_reg && !rev_s && !ld_s |=> !switch_on)
      else $error("switch on during undervoltage");
   dump_hold_a: assert property (ld_s && !rev_s |=> $stable(switch_on))
      else $error("switch state changed during load dump");
   rev_on_a: assert property (rev_s |=> switch_on)
      else $error("switch not forced on in reverse battery");
   recov_ind_a: assert property (state_reg == ST_RECOVER && !vout_s && en_s && !fault_any |=> sense_output)
      else $error("fault indication dropped before output rose");
   pin_rel_a: assert property (sense_output |-> !fault_open_drain_oe)
      else $error("fault pin driven during fault");
   retry_len_a: assert property ($rose(retry_done_reg) |-> $past(retry_cnt_reg) == RETRY_MAX)
      else $error("retry interval wrong length");

   trip_c: cover property (state_reg == ST_RUN ##1 state_reg == ST_HOLD);
   recover_c: cover property (state_reg == ST_RECOVER ##1 state_reg == ST_RUN);
   halved_c: cover property ($rose(limit_halved));

endmodule : swfp_ctrl

/* File: swfp_mcu_model.sv */
// Purpose: controller model driving enable and hold pins
// Assumes: supply_ok is low while the supply sits in lockout
// Notes:   enable is gated so a slow ramp never sees it high
`timescale 1ns/1ps
module swfp_mcu_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // requests
   input  wire logic supply_ok,
   input  wire logic want_on,
   input  wire logic want_hold,
   // pins
   output logic      en_pin,
   output logic      hold_pin
);
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         en_pin   <= 1'b0;
         hold_pin <= 1'b0;
      end else begin
         en_pin   <= want_on & supply_ok;
         hold_pin <= want_hold;
      end
   end
endmodule : swfp_mcu_model

/* File: test_switch_fault_protection_control.sv */
// Purpose: self-checking bench for the switch fault control
// Assumes: retry shortened to 20 cycles
// Notes:   outputs sampled at the falling edge, away from updates
`timescale 1ns/1ps
module test_switch_fault_protection_control
   import swfp_pkg::*;
;
   logic        ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, en_pin, hold_pin, limit_set_ok_pin, uv_fall_pin, uv_rise_pin;
   logic        load_dump_pin, rev_batt_pin, vout_high_pin, temp_abs_pin, temp_cool_pin;
   logic        temp_rel_pin, want_on, want_hold, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, switch_on, sense_output, fault_open_drain_out;
   logic        fault_open_drain_oe, limit_internal, limit_halved;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, fet_temp_c, limit_scale;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb, i_over_pin;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   int          failures = 0, cmp_count = 0;

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   swfp_ctrl #(.RETRY_CYCLES(20)) u_dut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .en_pin,
      .hold_pin, .limit_set_ok_pin, .uv_fall_pin, .uv_rise_pin, .load_dump_pin,
      .rev_batt_pin, .vout_high_pin, .temp_abs_pin, .temp_cool_pin, .temp_rel_pin,
      .i_over_pin, .fet_temp_c, .switch_on, .sense_output, .fault_open_drain_out,
      .fault_open_drain_oe, .limit_internal, .limit_halved, .limit_scale);
   swfp_mcu_model u_mcu (.ref_clk, .rstn, .supply_ok(!uv_fall_pin), .want_on, .want_hold,
      .en_pin, .hold_pin);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   // bounded wait, a used-up bound ends the run
   task automatic wait_sw(input logic v, input int lim);
      int n;
      for (n = 0; n < lim && switch_on !== v; n++) @(negedge ref_clk);
      check("switch_on", switch_on, v);
      if (switch_on !== v) print_verdict();
   endtask : wait_sw
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      int n;
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         aw = s_axi_awvalid & s_axi_awready;
         w  = s_axi_wvalid & s_axi_wready;
         b  = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge ref_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) break;
      end
      s_axi_bready <= 1'b0;
      check("bvalid", b, 1'b1);
      if (!b) print_verdict();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      logic ar, r;
      int n;
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         ar = s_axi_arvalid & s_axi_arready;
         r  = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge ref_clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) break;
      end
      s_axi_rready <= 1'b0;
      check("rvalid", r, 1'b1);
      if (!r) print_verdict();
   endtask : axi_rd

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      axi_rd(ADDR_CTRL);
      check("ctrl", rd, 32'h0000_0002);
      axi_rd(8'h08);
      check("rresp", rs, RESP_SLVERR);
      check("rdata", rd, 32'h0);
      axi_wr(8'h08, 32'h0000_0004);
      check("bresp", rs, RESP_SLVERR);
      @(posedge ref_clk) limit_set_ok_pin <= 1'b0;
      cyc(5);
      check("limit_internal", limit_internal, 1'b1);
      @(posedge ref_clk) limit_set_ok_pin <= 1'b1;
      axi_wr(ADDR_CTRL, 32'h0000_0004);
      cyc(5);
      check("limit_internal", limit_internal, 1'b1);
      check("limit_scale", limit_scale, 8'hFF);
      check("fault_oe", fault_open_drain_oe, 1'b1);
      @(posedge ref_clk) fet_temp_c <= 8'h64;
      cyc(3);
      check("limit_scale", limit_scale, 8'h8F);
   endtask : t_regs
   task automatic t_power();
      @(posedge ref_clk) {uv_fall_pin, uv_rise_pin, want_on} <= 3'b011;
      wait_sw(1, 10);
      @(posedge ref_clk) load_dump_pin <= 1'b1;
      cyc(4);
      @(posedge ref_clk) want_on <= 1'b0;
      cyc(10);
      check("switch_on", switch_on, 1'b1);
      @(posedge ref_clk) {load_dump_pin, rev_batt_pin} <= 2'b01;
      cyc(10);
      check("switch_on", switch_on, 1'b1);
      @(posedge ref_clk) rev_batt_pin <= 1'b0;
      wait_sw(0, 10);
      @(posedge ref_clk) want_on <= 1'b1;
      wait_sw(1, 10);
      @(posedge ref_clk) {uv_fall_pin, uv_rise_pin} <= 2'b10;
      wait_sw(0, 10);
      @(posedge ref_clk) {uv_fall_pin, uv_rise_pin} <= 2'b01;
      wait_sw(1, 10);
   endtask : t_power
   task automatic t_ocur();
      @(posedge ref_clk) {want_hold, i_over_pin} <= 5'h1F;
      cyc(62);
      check("switch_on", switch_on, 1'b1);
      wait_sw(0, 3);
      check("sense_output", sense_output, 1'b1);
      check("fault_oe", fault_open_drain_oe, 1'b0);
      check("fault_out", fault_open_drain_out, 1'b0);
      @(posedge ref_clk) i_over_pin <= 4'h0;
      cyc(40);
      check("switch_on", switch_on, 1'b0);
      @(posedge ref_clk) want_hold <= 1'b0;
      wait_sw(1, 10);
      check("sense_output", sense_output, 1'b1);
      @(posedge ref_clk) vout_high_pin <= 1'b1;
      cyc(5);
      check("sense_output", sense_output, 1'b0);
   endtask : t_ocur
   task automatic t_therm();
      @(posedge ref_clk) temp_abs_pin <= 1'b1;
      wait_sw(0, 10);
      @(posedge ref_clk) temp_abs_pin <= 1'b0;
      cyc(40);
      check("switch_on", switch_on, 1'b0);
      @(posedge ref_clk) temp_cool_pin <= 1'b1;
      wait_sw(1, 10);
      @(posedge ref_clk) temp_cool_pin <= 1'b0;
      repeat (5) begin
         @(posedge ref_clk) temp_rel_pin <= 1'b1;
         wait_sw(0, 10);
         @(posedge ref_clk) temp_rel_pin <= 1'b0;
         cyc(8);
         check("switch_on", switch_on, 1'b0);
         wait_sw(1, 40);
      end
      check("limit_halved", limit_halved, 1'b1);
      axi_rd(ADDR_STAT);
      check("fold_cnt", rd[STAT_CNT+:3], FOLD_COUNT);
      axi_wr(ADDR_CTRL, 32'h0000_0005);
      cyc(4);
      check("limit_halved", limit_halved, 1'b0);
   endtask : t_therm

   initial begin
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {want_on, want_hold, uv_rise_pin, load_dump_pin, rev_batt_pin, vout_high_pin} = '0;
      {temp_abs_pin, temp_cool_pin, temp_rel_pin, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, i_over_pin} = '0;
      {uv_fall_pin, limit_set_ok_pin, fet_temp_c, s_axi_wstrb} = {2'b11, 8'h19, 4'hF};
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_power();
      t_ocur();
      t_therm();
      print_verdict();
   end
endmodule : test_switch_fault_protection_control
